//--- pssup_evt_if.sv
// Condition and result pair between the supervisor and its qualifiers
`timescale 1ns/1ps
`default_nettype none
interface pssup_evt_if;
  logic cond;  // Triggering condition
  logic done;  // Condition qualified
  modport unit (input cond, output done);
  modport user (output cond, input done);
endinterface : pssup_evt_if
`default_nettype wire

//--- pssup_gate_model.sv
// Modulator and pulse-end model that drives the supervisor's gate request
`timescale 1ns/1ps
`default_nettype none
module pssup_gate_model (
  input  wire logic clk,          // Supervisor clock
  output logic      pwm_request,  // Gate wish, four cycles out of eight
  output logic      pulse_end     // Strobe that closes each pulse
);
  logic [2:0] phase_reg = 3'h0;  // Free-running, needs no reset
  // Step on the falling edge so the rising edge always samples settled levels
  always @(negedge clk) begin
    phase_reg <= phase_reg + 3'h1;
  end
  assign pwm_request = (phase_reg < 3'h4);
  assign pulse_end   = (phase_reg == 3'h4);
endmodule : pssup_gate_model
`default_nettype wire

//--- pssup_pkg.sv
// Constants, types and timing for the power stage protection supervisor
package pssup_pkg;
  // Counter width covers the longest delay at the clock rate
  localparam int TMR_W        = 26;
  localparam int CLK_KHZ      = 40_000;
  // Qualification and delay times in their own units
  localparam int UV_QUAL_US   = 10;
  localparam int OV_QUAL_US   = 10;
  localparam int TSD_QUAL_US  = 10;
  localparam int FLT_HI_US    = 50;
  localparam int FLT_LO_US    = 350;
  localparam int FB_OFF_MS    = 500;
  localparam int FAULT_TMR_MS = 128;
  localparam int AUTOREC_MS   = 1000;
  localparam int BO_TMR_MS    = 50;
  // Least times, rounded up to whole cycles
  localparam logic [TMR_W-1:0] UV_QUAL_CYC   = TMR_W'((UV_QUAL_US * CLK_KHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] OV_QUAL_CYC   = TMR_W'((OV_QUAL_US * CLK_KHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] TSD_QUAL_CYC  = TMR_W'((TSD_QUAL_US * CLK_KHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] FLT_HI_CYC    = TMR_W'((FLT_HI_US * CLK_KHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] FLT_LO_CYC    = TMR_W'((FLT_LO_US * CLK_KHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] FB_OFF_CYC    = TMR_W'(FB_OFF_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] FAULT_TMR_CYC = TMR_W'(FAULT_TMR_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] AUTOREC_CYC   = TMR_W'(AUTOREC_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] BO_TMR_CYC    = TMR_W'(BO_TMR_MS * CLK_KHZ);
  // Winding short pulse count
  localparam int              CNT_W        = 3;
  localparam logic [CNT_W-1:0] SHORT_PULSES = 3'h4;
  // Stop cause bit positions and reset value
  localparam int              STOP_W    = 3;
  localparam int              STOP_BO   = 0;
  localparam int              STOP_TSD  = 1;
  localparam int              STOP_FB   = 2;
  localparam logic [STOP_W-1:0] STOP_NONE = 3'h0;
  // Supervisor states
  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_SOFT  = 5'h02,
    ST_RUN   = 5'h04,
    ST_LATCH = 5'h08,
    ST_STOP  = 5'h10
  } pssup_state_t;
endpackage : pssup_pkg

//--- pssup_pulse_counter.sv
// Consecutive pulse counter for the winding short condition
`timescale 1ns/1ps
`default_nettype none
module pssup_pulse_counter (
  input  wire logic  clk,        // Supervisor clock
  input  wire logic  rst_n,      // Synchronised reset, active low
  input  wire logic  pulse_end,  // One-cycle strobe at each pulse end
  input  wire logic  clear,      // Hold the count at zero
  pssup_evt_if.unit  ev          // Short seen in ending pulse, trip out
);
  logic [pssup_pkg::CNT_W-1:0] cnt_reg;

  // A clean pulse breaks the run; the count saturates at the trip value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
    end else if (clear) begin
      cnt_reg <= 3'h0;
    end else if (pulse_end && !ev.cond) begin
      cnt_reg <= 3'h0;
    end else if (pulse_end && cnt_reg != pssup_pkg::SHORT_PULSES) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  assign ev.done = (cnt_reg == pssup_pkg::SHORT_PULSES);

  chk_count_break: assert property (@(posedge clk) disable iff (!rst_n)
    pulse_end && !ev.cond |=> cnt_reg == 3'h0)
    else $error("clean pulse did not reset the short count");
  chk_count_trip: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ev.done) |-> $past(pulse_end) && $past(ev.cond) && $past(cnt_reg) == 3'h3)
    else $error("short trip without the fourth consecutive pulse");
endmodule : pssup_pulse_counter
`default_nettype wire

//--- pssup_qual_timer.sv
// Qualification timer: done once its condition has held LIMIT cycles
`timescale 1ns/1ps
`default_nettype none
module pssup_qual_timer #(
  parameter logic [pssup_pkg::TMR_W-1:0] LIMIT = 26'h1
) (
  input  wire logic  clk,     // Supervisor clock
  input  wire logic  rst_n,   // Synchronised reset, active low
  pssup_evt_if.unit  ev       // Condition in, qualified out
);
  logic [pssup_pkg::TMR_W-1:0] cnt_reg;

  // Count while the condition holds, back to zero when it goes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 26'h0;
    end else if (!ev.cond) begin
      cnt_reg <= 26'h0;
    end else if (cnt_reg != LIMIT - 26'h1) begin
      cnt_reg <= cnt_reg + 26'h1;
    end
  end

  // Combinational so the trip acts in the cycle the count is reached
  assign ev.done = ev.cond && (cnt_reg == LIMIT - 26'h1);

  chk_timer_restart: assert property (@(posedge clk) disable iff (!rst_n)
    !ev.cond |=> (cnt_reg == 26'h0 && !ev.done))
    else $error("qualifier did not restart when its condition left");
  chk_timer_full_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ev.done) && (LIMIT > 26'h1) |-> $past(cnt_reg) == LIMIT - 26'h2)
    else $error("qualifier expired at the wrong count");
endmodule : pssup_qual_timer
`default_nettype wire

//--- pssup_top.sv
// Protection supervisor: fault qualification, latch-off and restart control
`timescale 1ns/1ps
`default_nettype none
module pssup_top #(
  parameter logic [pssup_pkg::TMR_W-1:0] FAULT_TMR_CYC = pssup_pkg::FAULT_TMR_CYC,
  parameter logic [pssup_pkg::TMR_W-1:0] AUTOREC_CYC   = pssup_pkg::AUTOREC_CYC,
  parameter logic [pssup_pkg::TMR_W-1:0] BO_TMR_CYC    = pssup_pkg::BO_TMR_CYC,
  parameter logic [pssup_pkg::TMR_W-1:0] FLT_LO_CYC    = pssup_pkg::FLT_LO_CYC,
  parameter logic [pssup_pkg::TMR_W-1:0] FB_OFF_CYC    = pssup_pkg::FB_OFF_CYC,
  parameter logic                        AUTOREC_VARIANT = 1'b1,
  parameter logic                        FAULT_AUTOREC   = 1'b0
) (
  input  wire logic ref_clk,                // 40 MHz clock
  input  wire logic rst_n,                  // Supply power-on reset, active low
  input  wire logic pwm_request,            // Gate request from the modulator
  input  wire logic pulse_end,              // Strobe when a gate pulse ends
  input  wire logic max_on_end,             // Pulse ended by max on-time
  input  wire logic max_duty_end,           // Pulse ended by max duty cycle
  input  wire logic cs_limit_hit,           // Setpoint at cs_limit_level
  input  wire logic cs_short_hit,           // Current sense above short level
  input  wire logic supply_undervolt_low,   // Supply below supply_undervolt_level
  input  wire logic supply_overvolt_high,   // Supply above supply_overvolt_level
  input  wire logic supply_start_ok,        // Supply above supply_start_level
  input  wire logic supply_clear_low,       // Supply below supply_clear_level
  input  wire logic line_stop_low,          // Line below line_stop_level
  input  wire logic line_start_ok,          // Line above line_start_level
  input  wire logic fault_hi_cmp,           // Fault input above high threshold
  input  wire logic fault_lo_cmp,           // Fault input below low threshold
  input  wire logic thermal_shutdown_hot,   // Die over temperature
  input  wire logic feedback_off_low,       // feedback_input below off level
  input  wire logic feedback_restart_ok,    // feedback_input above restart level
  input  wire logic soft_start_done,        // Soft-start ramp finished
  output logic      gate_drive_out,         // Gated switch drive
  output logic      soft_start_req,         // One-cycle soft-start launch
  output logic      thermistor_bias_boost,  // Select doubled bias current
  output logic      startup_source_en,      // High-voltage startup source on
  output logic      internal_supply_en,     // Internal supply on
  output logic      thermal_flag,           // Thermal stop remembered
  output logic      latched_off,            // Latched protection active
  output logic      stopped                 // Stop state active
);
  logic                          rst_meta_reg;
  logic                          rst_n_sync;
  pssup_pkg::pssup_state_t       state_reg;
  pssup_pkg::pssup_state_t       state_next;
  logic [pssup_pkg::STOP_W-1:0]  stop_reg;
  logic [pssup_pkg::STOP_W-1:0]  stop_next;
  logic                          latch_auto_reg;
  logic                          latch_auto_next;
  logic                          maxlim_pend_reg;
  logic                          short_hit_reg;
  logic                          gate_reg;
  logic                          ss_req_reg;
  logic                          boost_reg;
  logic                          active;
  logic                          trip_any;
  logic                          start_ok;
  logic                          stop_release;

  pssup_evt_if ovl_if ();
  pssup_evt_if short_if ();
  pssup_evt_if uv_if ();
  pssup_evt_if ov_if ();
  pssup_evt_if fhi_if ();
  pssup_evt_if flo_if ();
  pssup_evt_if tsd_if ();
  pssup_evt_if bo_if ();
  pssup_evt_if fb_if ();
  pssup_evt_if arec_if ();

  // Reset release through two flops; the supply reset still clears at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  assign active = (state_reg == pssup_pkg::ST_SOFT) || (state_reg == pssup_pkg::ST_RUN);

  // Remember a short seen during the pulse, since the comparator may drop first
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      short_hit_reg <= 1'b0;
    end else if (cs_short_hit && gate_reg) begin
      short_hit_reg <= 1'b1;
    end else if (pulse_end) begin
      short_hit_reg <= 1'b0;
    end
  end

  // Limit-ended pulses keep the fault timer running until a pulse ends normally
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      maxlim_pend_reg <= 1'b0;
    end else if (active && (max_on_end || max_duty_end)) begin
      maxlim_pend_reg <= 1'b1;
    end else if (!active || pulse_end) begin
      maxlim_pend_reg <= 1'b0;
    end
  end

  // Qualifier conditions, each but the short one gated to the states where it counts; its counter is cleared when not active
  assign ovl_if.cond   = active && (cs_limit_hit || maxlim_pend_reg);
  assign short_if.cond = short_hit_reg || cs_short_hit;
  assign uv_if.cond    = active && supply_undervolt_low;
  assign ov_if.cond    = active && supply_overvolt_high;
  // High fault armed once the supply has reached its start level
  assign fhi_if.cond   = fault_hi_cmp && (active ||
                         (state_reg == pssup_pkg::ST_OFF && supply_start_ok));
  // References settle late, so the low fault waits for the end of soft-start
  assign flo_if.cond   = fault_lo_cmp && (state_reg == pssup_pkg::ST_RUN);
  assign tsd_if.cond   = thermal_shutdown_hot && (state_reg != pssup_pkg::ST_STOP);
  assign bo_if.cond    = line_stop_low && !(state_reg == pssup_pkg::ST_STOP &&
                         stop_reg[pssup_pkg::STOP_BO]);
  assign fb_if.cond    = active && feedback_off_low;
  assign arec_if.cond  = (state_reg == pssup_pkg::ST_LATCH) && latch_auto_reg;

  pssup_qual_timer #(.LIMIT(FAULT_TMR_CYC)) u_ovl_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (ovl_if.unit)
  );
  pssup_pulse_counter u_short_cnt (
    .clk       (ref_clk),
    .rst_n     (rst_n_sync),
    .pulse_end (pulse_end),
    .clear     (!active),
    .ev        (short_if.unit)
  );
  pssup_qual_timer #(.LIMIT(pssup_pkg::UV_QUAL_CYC)) u_uv_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (uv_if.unit)
  );
  pssup_qual_timer #(.LIMIT(pssup_pkg::OV_QUAL_CYC)) u_ov_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (ov_if.unit)
  );
  pssup_qual_timer #(.LIMIT(pssup_pkg::FLT_HI_CYC)) u_fhi_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (fhi_if.unit)
  );
  pssup_qual_timer #(.LIMIT(FLT_LO_CYC)) u_flo_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (flo_if.unit)
  );
  pssup_qual_timer #(.LIMIT(pssup_pkg::TSD_QUAL_CYC)) u_tsd_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (tsd_if.unit)
  );
  pssup_qual_timer #(.LIMIT(BO_TMR_CYC)) u_bo_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (bo_if.unit)
  );
  pssup_qual_timer #(.LIMIT(FB_OFF_CYC)) u_fb_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (fb_if.unit)
  );
  pssup_qual_timer #(.LIMIT(AUTOREC_CYC)) u_arec_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n_sync),
    .ev    (arec_if.unit)
  );

  // Any latching cause; the fault window latches on either edge
  assign trip_any = ovl_if.done || short_if.done || uv_if.done || ov_if.done ||
                    fhi_if.done || flo_if.done;

  // A mixed trip is only recoverable when every cause is
  assign latch_auto_next = AUTOREC_VARIANT &&
                           !(ovl_if.done && maxlim_pend_reg) &&
                           !ov_if.done &&
                           !((fhi_if.done || flo_if.done) && !FAULT_AUTOREC);

  assign start_ok = supply_start_ok && line_start_ok && !fault_hi_cmp &&
                    !thermal_shutdown_hot;

  assign stop_release = line_start_ok && supply_start_ok &&
                        !(stop_reg[pssup_pkg::STOP_TSD] && thermal_shutdown_hot) &&
                        !(stop_reg[pssup_pkg::STOP_FB] && !feedback_restart_ok);

  // Next state; brown-out outranks thermal, then latching trips, then off mode
  always_comb begin
    state_next = state_reg;
    stop_next  = stop_reg;
    case (state_reg)
      pssup_pkg::ST_OFF, pssup_pkg::ST_SOFT, pssup_pkg::ST_RUN: begin
        if (bo_if.done) begin
          state_next = pssup_pkg::ST_STOP;
          stop_next  = 3'h1 << pssup_pkg::STOP_BO;
        end else if (tsd_if.done) begin
          state_next = pssup_pkg::ST_STOP;
          stop_next  = 3'h1 << pssup_pkg::STOP_TSD;
        end else if (trip_any) begin
          state_next = pssup_pkg::ST_LATCH;
        end else if (fb_if.done) begin
          state_next = pssup_pkg::ST_STOP;
          stop_next  = 3'h1 << pssup_pkg::STOP_FB;
        end else if (state_reg == pssup_pkg::ST_OFF && start_ok) begin
          state_next = pssup_pkg::ST_SOFT;
        end else if (state_reg == pssup_pkg::ST_SOFT && soft_start_done) begin
          state_next = pssup_pkg::ST_RUN;
        end
      end
      pssup_pkg::ST_LATCH: begin
        if (bo_if.done) begin
          state_next = pssup_pkg::ST_STOP;
          stop_next  = 3'h1 << pssup_pkg::STOP_BO;
        end else if (supply_clear_low || arec_if.done) begin
          state_next = pssup_pkg::ST_OFF;
        end
      end
      pssup_pkg::ST_STOP: begin
        if (supply_clear_low || stop_release) begin
          state_next = pssup_pkg::ST_OFF;
          stop_next  = pssup_pkg::STOP_NONE;
        end
      end
      default: begin
        state_next = pssup_pkg::ST_OFF;
        stop_next  = pssup_pkg::STOP_NONE;
      end
    endcase
  end

  // Supervisor state and stop cause
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= pssup_pkg::ST_OFF;
      stop_reg  <= pssup_pkg::STOP_NONE;
    end else begin
      state_reg <= state_next;
      stop_reg  <= stop_next;
    end
  end

  // Recoverability of the latch, fixed at the moment of the trip
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      latch_auto_reg <= 1'b0;
    end else if (state_next == pssup_pkg::ST_LATCH && state_reg != pssup_pkg::ST_LATCH) begin
      latch_auto_reg <= latch_auto_next;
    end
  end

  // Gate follows the request only while switching is allowed next cycle
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      gate_reg <= 1'b0;
    end else begin
      gate_reg <= pwm_request && (state_next == pssup_pkg::ST_SOFT ||
                  state_next == pssup_pkg::ST_RUN);
    end
  end

  // Soft-start launch and thermistor bias boost, only from a clean start
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ss_req_reg <= 1'b0;
      boost_reg  <= 1'b0;
    end else begin
      ss_req_reg <= (state_next == pssup_pkg::ST_SOFT) &&
                    (state_reg == pssup_pkg::ST_OFF);
      boost_reg  <= (state_next == pssup_pkg::ST_SOFT);
    end
  end

  assign gate_drive_out        = gate_reg;
  assign soft_start_req        = ss_req_reg;
  assign thermistor_bias_boost = boost_reg;
  assign latched_off           = (state_reg == pssup_pkg::ST_LATCH);
  assign stopped               = (state_reg == pssup_pkg::ST_STOP);
  // Thermal stop keeps supply for the flag but parks the startup source
  assign thermal_flag          = stopped && stop_reg[pssup_pkg::STOP_TSD];
  assign startup_source_en     = !thermal_flag;
  assign internal_supply_en    = !(stopped && stop_reg[pssup_pkg::STOP_FB]);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_trip_while_active;
    active && trip_any && !bo_if.done && !tsd_if.done;
  endsequence
  sequence s_in_latch;
    state_reg == pssup_pkg::ST_LATCH && !gate_drive_out;
  endsequence

  chk_gate_held_low: assert property (
    (latched_off || stopped) |-> !gate_drive_out && !soft_start_req)
    else $error("gate or soft-start active in a protection state");
  chk_trip_latches: assert property (
    s_trip_while_active |=> s_in_latch)
    else $error("qualified trip did not latch and stop the gate");
  chk_maxlim_no_auto: assert property (
    s_trip_while_active ##0 (ovl_if.done && maxlim_pend_reg) |=> !latch_auto_reg)
    else $error("limit-ended pulse latch marked recoverable");
  chk_ov_no_auto: assert property (
    s_trip_while_active ##0 ov_if.done |=> !latch_auto_reg)
    else $error("overvoltage latch marked recoverable");
  chk_fault_variant: assert property (
    s_trip_while_active ##0 (flo_if.done && !FAULT_AUTOREC) |=> !latch_auto_reg)
    else $error("fault latch recoverable in a latched variant");
  chk_autorec_release: assert property (
    latched_off && arec_if.done && !bo_if.done |=> state_reg == pssup_pkg::ST_OFF)
    else $error("autorecovery delay did not release the latch");
  chk_clear_release: assert property (
    latched_off && (supply_clear_low || bo_if.done) |=> !latched_off)
    else $error("brown-out or supply reset did not clear the latch");
  chk_hi_fault_wait: assert property (
    state_reg == pssup_pkg::ST_OFF && !supply_start_ok |-> !fhi_if.cond)
    else $error("high fault counted before supply start level");
  chk_lo_fault_wait: assert property (
    state_reg == pssup_pkg::ST_SOFT |-> !flo_if.cond)
    else $error("low fault counted during soft-start");
  chk_bias_boost: assert property (
    thermistor_bias_boost == (state_reg == pssup_pkg::ST_SOFT))
    else $error("bias boost not aligned with soft-start");
  chk_brownout_stop: assert property (
    bo_if.done && state_reg != pssup_pkg::ST_STOP |=> stopped ##0 startup_source_en)
    else $error("brown-out did not stop the device");
  chk_thermal_stop: assert property (
    active && tsd_if.done && !bo_if.done |=> !gate_drive_out && !startup_source_en)
    else $error("thermal shutdown did not stop gate and startup source");
  chk_fb_off_stop: assert property (
    active && fb_if.done && !bo_if.done && !tsd_if.done && !trip_any
    |=> stopped && !gate_drive_out && !internal_supply_en)
    else $error("feedback-off did not stop and drop the internal supply");
endmodule : pssup_top
`default_nettype wire

//--- test_power_stage_protection_supervisor.sv
// Self-checking bench for the protection supervisor
`timescale 1ns/1ps
`default_nettype none
module test_power_stage_protection_supervisor;
  logic ref_clk = 0, rst_n = 0, supply_start_ok = 1;
  logic supply_clear_low = 0, line_stop_low = 0, line_start_ok = 1, thermal_shutdown_hot = 0;
  logic feedback_off_low = 0, feedback_restart_ok = 1, soft_start_done = 0;
  logic [7:0] cause = 8'h00;  // Max duty, max on, fault hi, fault lo, over, under, short, limit
  wire logic cs_limit_hit, cs_short_hit, supply_undervolt_low, supply_overvolt_high;
  wire logic fault_lo_cmp, fault_hi_cmp;
  logic pwm_request, pulse_end, gate_drive_out, soft_start_req, thermistor_bias_boost;
  logic startup_source_en, internal_supply_en, thermal_flag, latched_off, stopped;
  int n_fail = 0, total_checks = 0, i, cyc = 0;
  assign {fault_hi_cmp, fault_lo_cmp, supply_overvolt_high} = cause[5:3];
  assign {supply_undervolt_low, cs_short_hit, cs_limit_hit} = cause[2:0];
  pssup_gate_model i_pssup_gate_model (
    .clk         (ref_clk),
    .pwm_request (pwm_request),
    .pulse_end   (pulse_end)
  );
  // Short counts keep the run brief; the waits below follow them, except the thermal and high fault waits, which follow the package times
  pssup_top #(.FAULT_TMR_CYC(26'h8), .AUTOREC_CYC(26'h10), .BO_TMR_CYC(26'h8),
    .FLT_LO_CYC(26'h14), .FB_OFF_CYC(26'h10), .AUTOREC_VARIANT(1'b1),
    .FAULT_AUTOREC(1'b0)) i_pssup_top (
    .ref_clk, .rst_n, .pwm_request, .pulse_end,
    // Limit-ended pulses arrive as strobes on the pulse end, as a modulator reports them
    .max_on_end   (cause[6] & pulse_end),
    .max_duty_end (cause[7] & pulse_end),
    .cs_limit_hit, .cs_short_hit, .supply_undervolt_low, .supply_overvolt_high,
    .supply_start_ok, .supply_clear_low, .line_stop_low, .line_start_ok,
    .fault_hi_cmp, .fault_lo_cmp, .thermal_shutdown_hot, .feedback_off_low,
    .feedback_restart_ok, .soft_start_done, .gate_drive_out, .soft_start_req,
    .thermistor_bias_boost, .startup_source_en, .internal_supply_en, .thermal_flag,
    .latched_off, .stopped
  );
  always #12.5 ref_clk = ~ref_clk;
  task chk(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Guard against a hang well beyond the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_fail++;
      results;
    end
  end
  // Soft-start may already be under way, so wait on the boost rather than the launch strobe
  task run_up;
    for (i = 0; i < 50 && thermistor_bias_boost !== 1'b1; i++) @(negedge ref_clk);
    chk(thermistor_bias_boost, 1'b1, "bias boost absent in soft-start");
    soft_start_done = 1;
    @(negedge ref_clk);
    soft_start_done = 0;
    chk(thermistor_bias_boost, 1'b0, "bias boost kept after soft-start");
    @(posedge pwm_request);
    @(negedge ref_clk);
    chk(gate_drive_out, 1'b1, "gate not following the request in run");
  endtask : run_up
  task wait_off(input int lim);
    for (i = 0; i < lim && latched_off !== 1'b1 && stopped !== 1'b1; i++) @(negedge ref_clk);
  endtask : wait_off
  task short_excursions;
    cause = 8'h10;
    repeat (30) @(negedge ref_clk);
    cause = 8'h00;
    run_up;
    chk(latched_off, 1'b0, "low fault counted during soft-start");
    cause = 8'h01;
    repeat (5) @(negedge ref_clk);
    cause = 8'h00;
    @(negedge ref_clk);
    cause = 8'h01;
    repeat (5) @(negedge ref_clk);
    cause = 8'h10;
    repeat (15) @(negedge ref_clk);
    cause = 8'h00;
    chk(latched_off, 1'b0, "latched on short excursions");
    $display("test end: short excursions");
  endtask : short_excursions
  task latch_causes;
    for (int k = 0; k < 8; k++) begin
      cause = 8'h01 << k;
      wait_off(2100);
      chk(latched_off, 1'b1, "cause did not latch");
      chk(gate_drive_out, 1'b0, "gate active while latched");
      cause = 8'h00;
      for (i = 0; i < 40 && soft_start_req !== 1'b1; i++) @(negedge ref_clk);
      chk(soft_start_req, (k < 3), "wrong autorecovery restart");
      chk(latched_off, (k > 2), "wrong autorecovery");
      // The last cause is cleared by a power-on reset in mid-run instead
      if (k == 7) rst_n = 0;
      else supply_clear_low = 1;
      repeat (2) @(negedge ref_clk);
      rst_n = 1;
      supply_clear_low = 0;
      chk(latched_off, 1'b0, "supply reset left latch");
      run_up;
    end
    $display("test end: latch causes");
  endtask : latch_causes
  task stops;
    line_stop_low = 1;
    line_start_ok = 0;
    wait_off(20);
    chk(stopped & ~gate_drive_out & startup_source_en, 1'b1, "no brown-out stop");
    cause = 8'h20;
    line_stop_low = 0;
    line_start_ok = 1;
    repeat (5) @(negedge ref_clk);
    chk(stopped | latched_off | thermistor_bias_boost, 1'b0, "start with high fault");
    cause = 8'h00;
    run_up;
    thermal_shutdown_hot = 1;
    wait_off(450);
    chk(~startup_source_en & thermal_flag, 1'b1, "no thermal stop");
    thermal_shutdown_hot = 0;
    repeat (3) @(negedge ref_clk);
    chk(stopped, 1'b0, "no thermal restart");
    run_up;
    feedback_off_low = 1;
    feedback_restart_ok = 0;
    wait_off(30);
    chk(stopped & ~internal_supply_en, 1'b1, "no feedback-off stop");
    feedback_off_low = 0;
    repeat (3) @(negedge ref_clk);
    chk(stopped, 1'b1, "restart without feedback");
    feedback_restart_ok = 1;
    repeat (2) @(negedge ref_clk);
    chk(stopped | ~internal_supply_en, 1'b0, "no feedback restart");
    $display("test end: stops");
  endtask : stops
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1;
    short_excursions;
    latch_causes;
    stops;
    results;
  end
endmodule : test_power_stage_protection_supervisor
`default_nettype wire
